// File: common/lmsc_pkg.sv
// Purpose: shared constants and types of the link mode and strap control block
// Assumes: 200 MHz system clock
// Notes: register offsets are byte addresses on the serial control bus
package lmsc_pkg;
    localparam int CLK_NS = 5;
    // register offsets
    localparam logic [7:0] OFF_ID_BRIDGE = 8'h4f;
    localparam logic [7:0] OFF_CFG = 8'h54;
    localparam logic [7:0] OFF_LINK = 8'h5b;
    localparam logic [7:0] OFF_STATUS = 8'h5c;
    localparam logic [7:0] OFF_FREQ = 8'h5d;
    // field positions
    localparam int ID_SRC_BIT = 0;
    localparam int AUX_BIT = 1;
    localparam int REMOTE_COPY_BIT = 5;
    localparam int OUTSIDE_CTL_BIT = 7;
    localparam int CABLE_BIT = 7;
    localparam int PLL_RESTART_BIT = 5;
    localparam int AUTO_OFF_BIT = 2;
    // reset values
    localparam logic [7:0] RST_ID_BRIDGE = 8'h00;
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [7:0] RST_LINK = 8'h20;
    // forced link mode codes, link_mode_control[1:0]
    localparam logic [1:0] FORCE_SINGLE = 2'h0;
    localparam logic [1:0] FORCE_DUAL = 2'h1;
    localparam logic [1:0] FORCE_REPL = 2'h2;
    localparam logic [1:0] FORCE_SEC = 2'h3;
    // control bus address from strap level
    localparam logic [6:0] BUS_ADDR_BASE = 7'h0c;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    // pixel clock measurement, one toggle per 16 pixels, count equals MHz
    localparam int WIN_NS = 16000;
    localparam int WIN_CYC = WIN_NS / CLK_NS;
    localparam logic [11:0] WIN_MAX = 12'(WIN_CYC - 1);
    localparam logic [7:0] SINGLE_MAX_MHZ = 8'h60;
    localparam logic [7:0] DUAL_MAX_MHZ = 8'haa;
    localparam logic [7:0] REPL_MAX_MHZ = 8'h55;
    localparam logic [7:0] DUAL_MIN_MHZ = 8'h61;
    // pixel buffer
    localparam int PIX_W = 24;
    localparam int PIX_D = 8;
    typedef enum logic [3:0] {
        LM_SINGLE = 4'b0001,
        LM_DUAL = 4'b0010,
        LM_REPL = 4'b0100,
        LM_SEC = 4'b1000
    } lmsc_mode_t;
    typedef enum logic [6:0] {
        I2C_IDLE = 7'b0000001,
        I2C_ADDR = 7'b0000010,
        I2C_ACK_ADDR = 7'b0000100,
        I2C_PTR = 7'b0001000,
        I2C_ACK_DATA = 7'b0010000,
        I2C_WDATA = 7'b0100000,
        I2C_RDATA = 7'b1000000
    } lmsc_i2c_t;
endpackage

// File: rtl/lmsc_fifo.sv
// Purpose: pixel buffer with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes: head word comes straight from the storage flops
`timescale 1ns/1ps
module lmsc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } lmsc_fifo_state_t;
    lmsc_fifo_state_t q;
    lmsc_fifo_state_t n;
    logic push;
    logic pop;

    assign in_ready = q.cnt != (AW+1)'(DEPTH);
    assign out_valid = q.cnt != '0;
    assign out_data = q.mem[q.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        n = q;
        if (push) begin
            n.mem[q.wp] = in_data;
            n.wp = q.wp + AW'(1);
        end
        if (pop) begin
            n.rp = q.rp + AW'(1);
        end
        if (push && !pop) begin
            n.cnt = q.cnt + (AW+1)'(1);
        end else if (pop && !push) begin
            n.cnt = q.cnt - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
endmodule

// File: rtl/lmsc_top.sv
// Purpose: strap loading, control bus target, link mode choice and pixel lane routing
// Assumes: strap levels arrive as level indices from the analog comparators
// Notes: control bus pins are open drain, only driven low
`timescale 1ns/1ps
// Operation
// [RQ1] decode second strap level into three bits
// [RQ2] aux audio strap into config bit 1
// [RQ3] display-id copy strap into config bit 5
// [RQ4] source, host control, cable strap bits land
// [RQ5] single mode sends one link, 96 MHz
// [RQ6] forced single disables secondary phy, back channel
// [RQ7] dual mode alternates pixels over two links
// [RQ8] dual up to 170 MHz, half rate
// [RQ9] auto dual for capable receiver, fast video
// [RQ10] replicate sends same video both links, 85 MHz
// [RQ11] two single receivers select replicate mode
// [RQ12] secondary-only receiver uses secondary link alone
// [RQ13] measure pixel clock to choose mode
// [RQ14] software can disable auto detection, force mode
// [RQ15] host clears pll restart bit after power-up
// [RQ16] host writes that after its setup
// [RQ17] bus address from id strap, 0x0c upward
// [RQ18] bus lines only driven low, never high
// [RQ19] straps latched into registers at power-up
// [RQ20] straps latched once at reset release
module lmsc_top (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // strap level indices, 0 is the lowest level
    input wire logic [1:0] first_mode_strap,
    input wire logic [2:0] second_mode_strap,
    input wire logic [2:0] bus_id_strap,
    // control bus pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // downstream detection and pixel clock tick
    input wire logic rx_primary_present,
    input wire logic rx_primary_dual_capable,
    input wire logic rx_secondary_present,
    input wire logic pclk_tick_toggle,
    // pixel input
    input wire logic pix_in_valid,
    input wire logic [lmsc_pkg::PIX_W-1:0] pix_in_data,
    output logic pix_in_ready,
    // primary lane
    output logic lane0_valid,
    output logic [lmsc_pkg::PIX_W-1:0] lane0_data,
    input wire logic lane0_ready,
    // secondary lane
    output logic lane1_valid,
    output logic [lmsc_pkg::PIX_W-1:0] lane1_data,
    input wire logic lane1_ready,
    // configuration and mode outputs
    output logic display_id_source,
    output logic aux_audio_enable,
    output logic outside_host_control,
    output logic remote_display_id_copy,
    output logic cable_kind_bit,
    output logic pll_restart_on_rate_change,
    output logic [6:0] bus_address,
    output logic [3:0] link_mode,
    output logic primary_tx_enable,
    output logic secondary_tx_enable,
    output logic secondary_back_channel_enable,
    output logic tx_half_rate,
    output logic rate_over_limit
);
    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_q;
        logic sda_q;
        lmsc_pkg::lmsc_i2c_t st;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic rw;
        logic sda_low;
        logic [7:0] r_id;
        logic [7:0] r_cfg;
        logic [7:0] r_link;
        logic [1:0] ms0a;
        logic [1:0] ms0b;
        logic [2:0] ms1a;
        logic [2:0] ms1b;
        logic [2:0] ida;
        logic [2:0] idb;
        logic [1:0] settle;
        logic loaded;
        logic [6:0] addr;
        logic [1:0] tog_s;
        logic tog_q;
        logic [11:0] win;
        logic [7:0] edges;
        logic [7:0] freq;
        lmsc_pkg::lmsc_mode_t mode;
        logic lane_sel;
        logic [1:0] sent;
    } lmsc_state_t;

    lmsc_state_t q;
    lmsc_state_t n;
    logic scl_h;
    logic sda_h;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic wr_en;
    logic tick;
    logic over;
    logic auto_off;
    logic forced_single;
    logic need0;
    logic need1;
    logic f_valid;
    logic f_pop;
    logic [lmsc_pkg::PIX_W-1:0] f_data;

    // register read decode
    function automatic logic [7:0] lmsc_read(input logic [7:0] a, input lmsc_state_t s,
                                             input logic ovr);
        logic [7:0] v;
        v = 8'h00;
        if (a == lmsc_pkg::OFF_ID_BRIDGE) begin
            v = s.r_id;
        end else if (a == lmsc_pkg::OFF_CFG) begin
            v = s.r_cfg;
        end else if (a == lmsc_pkg::OFF_LINK) begin
            v = s.r_link;
        end else if (a == lmsc_pkg::OFF_STATUS) begin
            v = {3'h0, ovr, s.mode};
        end else if (a == lmsc_pkg::OFF_FREQ) begin
            v = s.freq;
        end
        return v;
    endfunction

    assign scl_h = q.scl_s[1];
    assign sda_h = q.sda_s[1];
    assign scl_rise = scl_h & ~q.scl_q;
    assign scl_fall = ~scl_h & q.scl_q;
    assign bus_start = scl_h & q.scl_q & ~sda_h & q.sda_q;
    assign bus_stop = scl_h & q.scl_q & sda_h & ~q.sda_q;
    assign tick = q.tog_s[1] ^ q.tog_q;
    assign auto_off = q.r_link[lmsc_pkg::AUTO_OFF_BIT];
    assign forced_single = auto_off && q.r_link[1:0] == lmsc_pkg::FORCE_SINGLE;
    assign over = ((q.mode == lmsc_pkg::LM_SINGLE || q.mode == lmsc_pkg::LM_SEC)
                   && q.freq > lmsc_pkg::SINGLE_MAX_MHZ) // [RQ5]
               || (q.mode == lmsc_pkg::LM_DUAL && q.freq > lmsc_pkg::DUAL_MAX_MHZ) // [RQ8]
               || (q.mode == lmsc_pkg::LM_REPL && q.freq > lmsc_pkg::REPL_MAX_MHZ); // [RQ10]

    // lane routing per mode
    assign need0 = q.mode == lmsc_pkg::LM_SINGLE || q.mode == lmsc_pkg::LM_REPL
                || (q.mode == lmsc_pkg::LM_DUAL && !q.lane_sel); // [RQ7]
    assign need1 = q.mode == lmsc_pkg::LM_SEC || q.mode == lmsc_pkg::LM_REPL
                || (q.mode == lmsc_pkg::LM_DUAL && q.lane_sel); // [RQ12]
    assign lane0_valid = f_valid & need0 & ~q.sent[0];
    assign lane1_valid = f_valid & need1 & ~q.sent[1];
    assign lane0_data = f_data;
    assign lane1_data = f_data; // [RQ10]
    assign f_pop = f_valid & (~need0 | q.sent[0] | lane0_ready)
                 & (~need1 | q.sent[1] | lane1_ready);

    lmsc_fifo #(
        .WIDTH(lmsc_pkg::PIX_W),
        .DEPTH(lmsc_pkg::PIX_D)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(pix_in_valid),
        .in_data(pix_in_data),
        .in_ready(pix_in_ready),
        .out_valid(f_valid),
        .out_data(f_data),
        .out_ready(f_pop)
    );

    always_comb begin
        logic [7:0] rdv;
        rdv = 8'h00;
        n = q;
        wr_en = 1'b0;
        n.scl_s = {q.scl_s[0], scl_in};
        n.sda_s = {q.sda_s[0], sda_in};
        n.scl_q = scl_h;
        n.sda_q = sda_h;
        n.ms0a = first_mode_strap;
        n.ms0b = q.ms0a;
        n.ms1a = second_mode_strap;
        n.ms1b = q.ms1a;
        n.ida = bus_id_strap;
        n.idb = q.ida;
        n.tog_s = {q.tog_s[0], pclk_tick_toggle};
        n.tog_q = q.tog_s[1];
        // control bus target
        if (bus_start) begin
            n.st = lmsc_pkg::I2C_ADDR;
            n.bitn = 4'h0;
            n.sda_low = 1'b0;
        end else if (bus_stop) begin
            n.st = lmsc_pkg::I2C_IDLE;
            n.sda_low = 1'b0;
        end else if (scl_rise) begin
            case (q.st)
                lmsc_pkg::I2C_ADDR, lmsc_pkg::I2C_PTR, lmsc_pkg::I2C_WDATA: begin
                    n.sh = {q.sh[6:0], sda_h};
                    n.bitn = q.bitn + 4'h1;
                end
                lmsc_pkg::I2C_RDATA: begin
                    n.bitn = q.bitn + 4'h1;
                end
                lmsc_pkg::I2C_ACK_DATA: begin
                    if (q.rw && sda_h) begin
                        n.st = lmsc_pkg::I2C_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (q.st)
                lmsc_pkg::I2C_ADDR: begin
                    if (q.bitn == 4'h8) begin
                        if (q.sh[7:1] == q.addr) begin // [RQ17]
                            n.st = lmsc_pkg::I2C_ACK_ADDR;
                            n.rw = q.sh[0];
                            n.sda_low = 1'b1;
                        end else begin
                            n.st = lmsc_pkg::I2C_IDLE;
                        end
                    end
                end
                lmsc_pkg::I2C_ACK_ADDR: begin
                    n.bitn = 4'h0;
                    n.sda_low = 1'b0;
                    if (q.rw) begin
                        rdv = lmsc_read(q.ptr, q, over);
                        n.sh = rdv;
                        n.sda_low = ~rdv[7];
                        n.st = lmsc_pkg::I2C_RDATA;
                    end else begin
                        n.st = lmsc_pkg::I2C_PTR;
                    end
                end
                lmsc_pkg::I2C_PTR: begin
                    if (q.bitn == 4'h8) begin
                        n.ptr = q.sh;
                        n.sda_low = 1'b1;
                        n.st = lmsc_pkg::I2C_ACK_DATA;
                    end
                end
                lmsc_pkg::I2C_WDATA: begin
                    if (q.bitn == 4'h8) begin
                        wr_en = 1'b1;
                        n.ptr = q.ptr + 8'h01;
                        n.sda_low = 1'b1;
                        n.st = lmsc_pkg::I2C_ACK_DATA;
                    end
                end
                lmsc_pkg::I2C_RDATA: begin
                    if (q.bitn == 4'h8) begin
                        n.sda_low = 1'b0;
                        n.ptr = q.ptr + 8'h01;
                        n.st = lmsc_pkg::I2C_ACK_DATA;
                    end else begin
                        n.sh = {q.sh[6:0], 1'b0};
                        n.sda_low = ~q.sh[6];
                    end
                end
                lmsc_pkg::I2C_ACK_DATA: begin
                    n.bitn = 4'h0;
                    n.sda_low = 1'b0;
                    n.st = lmsc_pkg::I2C_WDATA;
                    if (q.rw) begin
                        rdv = lmsc_read(q.ptr, q, over);
                        n.sh = rdv;
                        n.sda_low = ~rdv[7];
                        n.st = lmsc_pkg::I2C_RDATA;
                    end
                end
                default: begin
                end
            endcase
        end
        // register writes may override strapped values
        if (wr_en) begin
            if (q.ptr == lmsc_pkg::OFF_ID_BRIDGE) begin
                n.r_id = q.sh; // [RQ4]
            end else if (q.ptr == lmsc_pkg::OFF_CFG) begin
                n.r_cfg = q.sh; // [RQ2]
            end else if (q.ptr == lmsc_pkg::OFF_LINK) begin
                n.r_link = q.sh; // [RQ14]
            end
        end
        // one strap capture after reset release
        if (!q.loaded) begin
            if (q.settle == lmsc_pkg::STRAP_SETTLE) begin
                n.loaded = 1'b1; // [RQ20]
                n.r_id[lmsc_pkg::ID_SRC_BIT] = q.ms0b[1]; // [RQ4]
                n.r_cfg[lmsc_pkg::AUX_BIT] = q.ms0b[0]; // [RQ2]
                n.r_cfg[lmsc_pkg::OUTSIDE_CTL_BIT] = q.ms1b[2]; // [RQ1]
                n.r_link[lmsc_pkg::CABLE_BIT] = q.ms1b[1]; // [RQ1]
                n.r_cfg[lmsc_pkg::REMOTE_COPY_BIT] = q.ms1b[0]; // [RQ3]
                n.addr = lmsc_pkg::BUS_ADDR_BASE + {3'h0, q.idb, 1'b0}; // [RQ17]
            end else begin
                n.settle = q.settle + 2'h1; // [RQ19]
            end
        end
        // pixel clock rate in MHz over a fixed window
        if (q.win == lmsc_pkg::WIN_MAX) begin
            n.win = 12'h000;
            n.freq = q.edges; // [RQ13]
            n.edges = {7'h00, tick};
        end else begin
            n.win = q.win + 12'h001;
            if (tick && q.edges != 8'hff) begin
                n.edges = q.edges + 8'h01;
            end
        end
        // link mode choice
        if (auto_off) begin
            case (q.r_link[1:0]) // [RQ14]
                lmsc_pkg::FORCE_DUAL: n.mode = lmsc_pkg::LM_DUAL;
                lmsc_pkg::FORCE_REPL: n.mode = lmsc_pkg::LM_REPL;
                lmsc_pkg::FORCE_SEC: n.mode = lmsc_pkg::LM_SEC;
                default: n.mode = lmsc_pkg::LM_SINGLE;
            endcase
        end else if (rx_primary_present && rx_primary_dual_capable
                     && q.freq >= lmsc_pkg::DUAL_MIN_MHZ) begin
            n.mode = lmsc_pkg::LM_DUAL; // [RQ9]
        end else if (rx_primary_present && rx_secondary_present) begin
            n.mode = lmsc_pkg::LM_REPL; // [RQ11]
        end else if (!rx_primary_present && rx_secondary_present) begin
            n.mode = lmsc_pkg::LM_SEC; // [RQ12]
        end else begin
            n.mode = lmsc_pkg::LM_SINGLE; // [RQ5]
        end
        // lane hand-off bookkeeping
        if (f_pop) begin
            n.sent = 2'b00;
            n.lane_sel = (q.mode == lmsc_pkg::LM_DUAL) ? ~q.lane_sel : 1'b0; // [RQ7]
        end else begin
            n.sent = q.sent | {lane1_valid & lane1_ready, lane0_valid & lane0_ready};
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
            q.scl_s <= 2'h3;
            q.sda_s <= 2'h3;
            q.scl_q <= 1'b1;
            q.sda_q <= 1'b1;
            q.st <= lmsc_pkg::I2C_IDLE;
            q.mode <= lmsc_pkg::LM_SINGLE;
            q.r_id <= lmsc_pkg::RST_ID_BRIDGE;
            q.r_cfg <= lmsc_pkg::RST_CFG;
            q.r_link <= lmsc_pkg::RST_LINK;
            q.addr <= lmsc_pkg::BUS_ADDR_BASE;
        end else begin
            q <= n;
        end
    end

    // open drain: never drive high
    assign scl_out = 1'b0;
    assign scl_oe = 1'b0;
    assign sda_out = 1'b0;
    assign sda_oe = q.sda_low; // [RQ18]
    assign display_id_source = q.r_id[lmsc_pkg::ID_SRC_BIT];
    assign aux_audio_enable = q.r_cfg[lmsc_pkg::AUX_BIT];
    assign outside_host_control = q.r_cfg[lmsc_pkg::OUTSIDE_CTL_BIT];
    assign remote_display_id_copy = q.r_cfg[lmsc_pkg::REMOTE_COPY_BIT];
    assign cable_kind_bit = q.r_link[lmsc_pkg::CABLE_BIT];
    assign pll_restart_on_rate_change = q.r_link[lmsc_pkg::PLL_RESTART_BIT]; // [RQ15]
    assign bus_address = q.addr;
    assign link_mode = q.mode;
    assign primary_tx_enable = q.mode != lmsc_pkg::LM_SEC;
    assign secondary_tx_enable = q.mode != lmsc_pkg::LM_SINGLE; // [RQ6]
    assign secondary_back_channel_enable = secondary_tx_enable
                                        | (rx_secondary_present & ~forced_single); // [RQ6]
    assign tx_half_rate = q.mode == lmsc_pkg::LM_DUAL; // [RQ8]
    assign rate_over_limit = over;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    property p_strap_decode;
        $rose(q.loaded) |-> q.r_cfg[7] == $past(q.ms1b[2]) && q.r_link[7] == $past(q.ms1b[1]);
    endproperty
    a_strap_decode: assert property (p_strap_decode) else $error("strap decode wrong"); // [RQ1]
    property p_aux;
        $rose(q.loaded) |-> q.r_cfg[1] == $past(q.ms0b[0]);
    endproperty
    a_aux: assert property (p_aux) else $error("aux strap not latched"); // [RQ2]
    property p_copy;
        $rose(q.loaded) |-> q.r_cfg[5] == $past(q.ms1b[0]) && q.r_id[0] == $past(q.ms0b[1]);
    endproperty
    a_copy: assert property (p_copy) else $error("copy or source strap wrong"); // [RQ3]
    property p_addr;
        $rose(q.loaded) |-> bus_address == 7'h0c + {3'h0, $past(q.idb), 1'b0};
    endproperty
    a_addr: assert property (p_addr) else $error("bus address wrong"); // [RQ17]
    property p_once;
        q.loaded && $past(q.loaded) && !$past(wr_en) |-> $stable(q.r_cfg) && $stable(q.r_id);
    endproperty
    a_once: assert property (p_once) else $error("register changed without write"); // [RQ20]
    property p_single;
        forced_single ##1 forced_single |-> !secondary_tx_enable && !secondary_back_channel_enable;
    endproperty
    a_single: assert property (p_single) else $error("secondary on in forced single"); // [RQ6]
    property p_alternate;
        f_pop && q.mode == lmsc_pkg::LM_DUAL && !q.lane_sel |=> q.lane_sel;
    endproperty
    a_alternate: assert property (p_alternate) else $error("dual lanes not alternating"); // [RQ7]
    property p_auto_dual;
        !auto_off && rx_primary_present && rx_primary_dual_capable && q.freq >= 8'h61
            && $stable(q.freq) |=> q.mode == lmsc_pkg::LM_DUAL;
    endproperty
    a_auto_dual: assert property (p_auto_dual) else $error("dual not chosen"); // [RQ9]
    property p_repl;
        !auto_off && rx_primary_present && rx_secondary_present && !rx_primary_dual_capable
            |=> q.mode == lmsc_pkg::LM_REPL;
    endproperty
    a_repl: assert property (p_repl) else $error("replicate not chosen"); // [RQ11]
    property p_sec_only;
        !auto_off && !rx_primary_present && rx_secondary_present |=> !primary_tx_enable;
    endproperty
    a_sec_only: assert property (p_sec_only) else $error("primary used without receiver"); // [RQ12]
    property p_freq;
        q.win == 12'hc7f |=> q.freq == $past(q.edges) && q.win == 12'h000;
    endproperty
    a_freq: assert property (p_freq) else $error("rate not captured"); // [RQ13]
    property p_sda;
        sda_oe |-> !sda_out && (q.st == lmsc_pkg::I2C_ACK_ADDR || q.st == lmsc_pkg::I2C_ACK_DATA
            || q.st == lmsc_pkg::I2C_RDATA);
    endproperty
    a_sda: assert property (p_sda) else $error("data line driven out of turn"); // [RQ18]
endmodule

// File: testbench/lmsc_host.sv
// Purpose: control bus host model
// Assumes: pull-ups on both lines
// Notes: lines are only pulled low or released
`timescale 1ns/1ps
module lmsc_host (
    // clock
    input wire logic clk,
    // bus lines
    input wire logic scl_oe,
    input wire logic sda_oe,
    output logic scl_in,
    output logic sda_in
);
    logic scl_low = 1'b0;
    logic sda_low = 1'b0;
    logic r;
    assign scl_in = !(scl_low | scl_oe);
    assign sda_in = !(sda_low | sda_oe);
    task automatic wt();
        repeat (8) @(negedge clk);
    endtask
    task automatic bx(input logic b);
        sda_low = !b;
        wt();
        scl_low = 1'b0;
        wt();
        r = sda_in;
        scl_low = 1'b1;
    endtask
    task automatic go();
        sda_low = 1'b0;
        wt();
        scl_low = 1'b0;
        wt();
        sda_low = 1'b1;
        wt();
        scl_low = 1'b1;
    endtask
    task automatic stp();
        sda_low = 1'b1;
        wt();
        scl_low = 1'b0;
        wt();
        sda_low = 1'b0;
        wt();
    endtask
    task automatic tx(input logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            bx(d[i]);
        bx(1'b1);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d);
        go();
        tx({a, 1'b0});
        tx(o);
        tx(d);
        stp();
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] o, output logic [7:0] d);
        go();
        tx({a, 1'b0});
        tx(o);
        go();
        tx({a, 1'b1});
        d = 8'h00;
        for (int i = 0; i < 8; i++) begin
            bx(1'b1);
            d = {d[6:0], r};
        end
        bx(1'b1);
        stp();
    endtask
endmodule

// File: testbench/lmsc_top_tb.sv
// Purpose: self-checking bench of the strap and link mode block
// Assumes: host model on the bus, random lane stalls
// Notes: lane results matched against per-lane queues
`timescale 1ns/1ps
module lmsc_top_tb;
    logic clk = 1'b0, reset = 1'b1, pp = 1'b0, dc = 1'b0, sp = 1'b0, tg = 1'b0;
    logic piv = 1'b0, r0 = 1'b0, r1 = 1'b0;
    logic [1:0] s1 = 2'h0;
    logic [2:0] s2 = 3'h0, sid = 3'h0;
    logic [23:0] pid = 24'h0, d0, d1;
    logic so, se, di, ds, pir, v0, v1, ids, aux, ohc, rdc, cab, pll, pe, sx, sb, hf, ov;
    logic [6:0] ba;
    logic [3:0] lm;
    logic [7:0] rv;
    logic [11:0] st;
    logic [23:0] q0[$], q1[$];
    int fails = 0, checks_done = 0;
    always #2.5 clk = ~clk;
    always #160 tg = ~tg;
    lmsc_host h (.clk(clk), .scl_oe(so), .sda_oe(se), .scl_in(di), .sda_in(ds));
    lmsc_top DUT (.clk(clk), .reset(reset), .first_mode_strap(s1), .second_mode_strap(s2),
        .bus_id_strap(sid), .scl_in(di), .scl_out(), .scl_oe(so), .sda_in(ds), .sda_out(),
        .sda_oe(se), .rx_primary_present(pp), .rx_primary_dual_capable(dc),
        .rx_secondary_present(sp), .pclk_tick_toggle(tg), .pix_in_valid(piv), .pix_in_data(pid),
        .pix_in_ready(pir), .lane0_valid(v0), .lane0_data(d0), .lane0_ready(r0),
        .lane1_valid(v1), .lane1_data(d1), .lane1_ready(r1), .display_id_source(ids),
        .aux_audio_enable(aux), .outside_host_control(ohc), .remote_display_id_copy(rdc),
        .cable_kind_bit(cab), .pll_restart_on_rate_change(pll), .bus_address(ba),
        .link_mode(lm), .primary_tx_enable(pe), .secondary_tx_enable(sx),
        .secondary_back_channel_enable(sb), .tx_half_rate(hf), .rate_over_limit(ov));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (fails == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(negedge clk) begin
        r0 <= 1'($urandom);
        r1 <= 1'($urandom);
    end
    always @(posedge clk) begin
        if (v0 && r0) chk(d0, q0.pop_front());
        if (v1 && r1) chk(d1, q1.pop_front());
    end
    initial begin
        #400000;
        fails++;
        test_done();
    end
    initial begin
        void'($urandom(60924));
        {s1, s2, sid} = 8'($urandom);
        repeat (6) @(negedge clk);
        reset = 1'b0;
        repeat (12) @(negedge clk);
        st = {7'h0c + {3'h0, sid, 1'b0}, s1, s2};
        chk({ba, ids, aux, ohc, cab, rdc, pll}, {st, 1'b1});
        {s1, s2, sid} = ~{s1, s2, sid};
        repeat (12) @(negedge clk);
        chk({ba, ids, aux, ohc, cab, rdc}, st);
        h.rd(st[11:5], 8'h54, rv);
        chk(rv, {st[2], 1'b0, st[0], 3'h0, st[3], 1'b0});
        h.wr(st[11:5], 8'h4f, 8'h01);
        chk(ids, 1'b1);
        for (int m = 0; m < 4; m++) begin
            h.wr(st[11:5], 8'h5b, 8'h04 | 8'(m));
            repeat (4) @(negedge clk);
            chk({lm, hf, sb, pe, pll, cab}, {4'h1 << m, m == 1, m != 0, m != 3, 2'h0});
            chk(sx, m != 0);
            for (int i = 0; i < 6; i++) begin
                pid = 24'($urandom);
                if (m != 3 && !(m == 1 && i[0])) q0.push_back(pid);
                if (m != 0 && !(m == 1 && !i[0])) q1.push_back(pid);
                @(negedge clk);
                piv = 1'b1;
                while (!pir) @(negedge clk);
                @(negedge clk);
                piv = 1'b0;
            end
            repeat (60) @(negedge clk);
            chk(q0.size() + q1.size(), 0);
        end
        h.wr(st[11:5], 8'h5b, 8'h00);
        for (int k = 0; k < 3; k++) begin
            {pp, dc, sp} = k == 0 ? 3'b110 : (k == 1 ? 3'b101 : 3'b001);
            repeat (7000) @(negedge clk);
            chk({lm, hf, ov}, k == 0 ? 6'h0a : (k == 1 ? 6'h11 : 6'h21));
        end
        h.rd(st[11:5], 8'h5d, rv);
        chk(rv, 8'h64);
        test_done();
    end
endmodule
